// file: rtcc_pkg.sv
package rtcc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
    localparam int unsigned MISS_TIME_US  = 100;
    localparam int unsigned MISS_CYCLES   = (MISS_TIME_US * (CLK_FREQ_HZ / 1_000_000));

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_SNAP0      = 4'h0;
    localparam logic [3:0] OFS_SNAP1      = 4'h1;
    localparam logic [3:0] OFS_SNAP2      = 4'h2;
    localparam logic [3:0] OFS_SNAP3      = 4'h3;
    localparam logic [3:0] OFS_CONTROL    = 4'h4;
    localparam logic [3:0] OFS_MATCH0     = 4'h8;
    localparam logic [3:0] OFS_MATCH1     = 4'h9;
    localparam logic [3:0] OFS_MATCH2     = 4'hA;
    localparam logic [3:0] OFS_MATCH3     = 4'hB;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'hC;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'hD;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_OSC_EN    = 7;
    localparam int unsigned BIT_MCLK_EN   = 6;
    localparam int unsigned BIT_OSC_FAIL  = 5;
    localparam int unsigned BIT_RUN       = 4;
    localparam int unsigned BIT_ALARM_EN  = 3;
    localparam int unsigned BIT_ALARM     = 2;
    localparam int unsigned BIT_LOAD      = 1;
    localparam int unsigned BIT_SNAP      = 0;

    // ------------------------------------------------------------
    // Interrupt status fields
    // ------------------------------------------------------------
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned IRQ_ALARM     = 0;
    localparam int unsigned IRQ_OSC_FAIL  = 1;
    localparam int unsigned IRQ_LOAD_DONE = 2;
    localparam int unsigned IRQ_SNAP_DONE = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL   = 8'h00;
    localparam logic [31:0] RST_TIMER     = 32'h0000_0000;
    localparam logic [3:0]  RST_IRQ       = 4'h0;

endpackage : rtcc_pkg

// file: rtcc_osc_if.sv
`timescale 1ns/1ps
interface rtcc_osc_if;
    logic detect_en;
    logic osc_tick;
    logic fail_pulse;

    modport mon (
        input  detect_en,
        output osc_tick,
        output fail_pulse
    );

    modport core (
        output detect_en,
        input  osc_tick,
        input  fail_pulse
    );
endinterface : rtcc_osc_if

// file: rtcc_osc_mon.sv
`timescale 1ns/1ps
module rtcc_osc_mon
    import rtcc_pkg::*;
#(
    parameter int unsigned MISS_LIMIT = MISS_CYCLES
) (
    // Clock and reset
    input  wire logic   clock_in,
    input  wire logic   srst_in,
    // Oscillator pin
    input  wire logic   osc_clk_in,
    // Link to the core
    rtcc_osc_if.mon     osc
);

    // The idle counter is 16 bits wide and needs at least two counts.
    if (MISS_LIMIT < 2 || MISS_LIMIT > 65535) begin : g_bad_limit
        $error("MISS_LIMIT out of range");
    end

    // ------------------------------------------------------------
    // Pin synchroniser and edge detect
    // ------------------------------------------------------------
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        level;
    logic [15:0] idle_cnt;
    logic        fired;

    wire agree     = (sync2 == sync3);
    wire changed   = agree && (sync3 != level);
    wire rise      = changed && sync3;
    wire limit_hit = (idle_cnt == 16'(MISS_LIMIT - 1));

    always_ff @(posedge clock_in) begin
        sync1 <= osc_clk_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            level        <= 1'b0;
            osc.osc_tick <= 1'b0;
        end else begin
            if (changed) begin
                level <= sync3;
            end
            osc.osc_tick <= rise;
        end
    end

    // ------------------------------------------------------------
    // Missing-clock detector
    // ------------------------------------------------------------
    // One-shot: fires once per stall, rearmed by the next pin change.
    always_ff @(posedge clock_in) begin
        if (srst_in || !osc.detect_en || changed) begin
            idle_cnt       <= 16'h0000;
            fired          <= 1'b0;
            osc.fail_pulse <= 1'b0;
        end else begin
            osc.fail_pulse <= 1'b0;
            if (!fired) begin
                if (limit_hit) begin
                    fired          <= 1'b1;
                    osc.fail_pulse <= 1'b1;
                end else begin
                    idle_cnt <= idle_cnt + 16'h0001;
                end
            end
        end
    end

endmodule : rtcc_osc_mon

// file: rtcc_top.sv
`timescale 1ns/1ps
// How it works
// - Oscillator enable bit drives oscillator output.
// - Detector only runs with its enable set.
// - Detector timeout sets oscillator-fail flag.
// - Fail flag sticks until software clears it.
// - Run bit gates increment; zero stops counting but not load or auto-reset.
// - Alarm enable gates compare; write clears flag.
// - Reading alarm bit returns event flag.
// - Writing alarm bit stores auto-reset enable.
// - Load request copies holding regs; self-clears.
// - Snapshot request copies timer; self-clears.
// - Event flag lasts one tick unless the next tick also matches.
// - Running timer increments each oscillator tick.
// - Alarm when timer equals match value.
// - Auto-reset zeroes timer one tick later.
module rtcc_top
    import rtcc_pkg::*;
#(
    parameter int unsigned MISS_LIMIT = MISS_CYCLES
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              srst_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rdata_out,
    // Oscillator
    input  wire logic              osc_clk_in,
    output logic                   osc_enable_out,
    // Events
    output logic                   alarm_out,
    output logic                   irq_out
);

    // ------------------------------------------------------------
    // Oscillator monitor
    // ------------------------------------------------------------
    rtcc_osc_if osc ();

    rtcc_osc_mon #(
        .MISS_LIMIT (MISS_LIMIT)
    ) u_mon (
        .clock_in   (clock_in),
        .srst_in    (srst_in),
        .osc_clk_in (osc_clk_in),
        .osc        (osc)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic              osc_enable;
    logic              missing_clk_detect_enable;
    logic              osc_fail_flag;
    logic              timer_run;
    logic              alarm_enable;
    logic              alarm_flag;
    logic              autoreset_enable;
    logic              timer_load_request;
    logic              timer_snapshot_request;
    logic              clear_pending;
    logic [31:0]       timer;
    logic [31:0]       snapshot_holding_regs;
    logic [31:0]       alarm_match_regs;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;

    assign osc.detect_en = missing_clk_detect_enable;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_byte(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
        is_byte = (a[ADDR_W-1:2] == base[ADDR_W-1:2]);
    endfunction : is_byte

    wire          wr_ctl    = wr_in && (addr_in == OFS_CONTROL);
    wire          wr_snap   = wr_in && is_byte(addr_in, OFS_SNAP0);
    wire          wr_alarm  = wr_in && is_byte(addr_in, OFS_MATCH0);
    wire          wr_status = wr_in && (addr_in == OFS_IRQ_STATUS);
    wire          wr_mask   = wr_in && (addr_in == OFS_IRQ_MASK);
    wire [1:0]    lane      = addr_in[1:0];
    wire          tick      = osc.osc_tick;

    // ------------------------------------------------------------
    // Timer events
    // ------------------------------------------------------------
    wire alarm_hit  = tick && alarm_enable
                      && (timer == alarm_match_regs);
    wire do_load    = tick && timer_load_request;
    wire do_snap    = tick && timer_snapshot_request;
    wire do_clear   = tick && clear_pending && autoreset_enable;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            osc_enable                <= RST_CONTROL[BIT_OSC_EN];
            missing_clk_detect_enable <= RST_CONTROL[BIT_MCLK_EN];
            timer_run                 <= RST_CONTROL[BIT_RUN];
            alarm_enable              <= RST_CONTROL[BIT_ALARM_EN];
            autoreset_enable          <= RST_CONTROL[BIT_ALARM];
        end else if (wr_ctl) begin
            osc_enable                <= wdata_in[BIT_OSC_EN];
            missing_clk_detect_enable <= wdata_in[BIT_MCLK_EN];
            timer_run                 <= wdata_in[BIT_RUN];
            alarm_enable              <= wdata_in[BIT_ALARM_EN];
            autoreset_enable          <= wdata_in[BIT_ALARM];
        end
    end

    // A detector timeout in the same cycle as a clearing write wins.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            osc_fail_flag <= RST_CONTROL[BIT_OSC_FAIL];
        end else if (osc.fail_pulse) begin
            osc_fail_flag <= 1'b1;
        end else if (wr_ctl) begin
            osc_fail_flag <= wdata_in[BIT_OSC_FAIL];
        end
    end

    // ------------------------------------------------------------
    // Load and snapshot requests
    // ------------------------------------------------------------
    // Requests wait for the next oscillator tick, so the timer only
    // ever moves on tick boundaries; a zero write never cancels one.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            timer_load_request     <= RST_CONTROL[BIT_LOAD];
            timer_snapshot_request <= RST_CONTROL[BIT_SNAP];
        end else begin
            if (wr_ctl && wdata_in[BIT_LOAD]) begin
                timer_load_request <= 1'b1;
            end else if (do_load) begin
                timer_load_request <= 1'b0;
            end
            if (wr_ctl && wdata_in[BIT_SNAP]) begin
                timer_snapshot_request <= 1'b1;
            end else if (do_snap) begin
                timer_snapshot_request <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            timer <= RST_TIMER;
        end else if (do_load) begin
            timer <= snapshot_holding_regs;
        end else if (do_clear) begin
            timer <= RST_TIMER;
        end else if (tick && timer_run) begin
            timer <= timer + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Holding and match registers
    // ------------------------------------------------------------
    // A snapshot overrides a same-cycle software write to the bytes.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            snapshot_holding_regs <= RST_TIMER;
            alarm_match_regs      <= RST_TIMER;
        end else begin
            if (do_snap) begin
                snapshot_holding_regs <= timer;
            end else if (wr_snap) begin
                snapshot_holding_regs[lane*8 +: 8] <= wdata_in;
            end
            if (wr_alarm) begin
                alarm_match_regs[lane*8 +: 8] <= wdata_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Alarm event flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            alarm_flag    <= 1'b0;
            clear_pending <= 1'b0;
        end else begin
            if (alarm_hit) begin
                alarm_flag <= 1'b1;
            end else if (wr_ctl || tick) begin
                alarm_flag <= 1'b0;
            end
            if (tick) begin
                clear_pending <= alarm_hit;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [IRQ_W-1:0] irq_set = {do_snap, do_load, osc.fail_pulse, alarm_hit};

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_status <= RST_IRQ;
            irq_mask   <= RST_IRQ;
        end else begin
            irq_status <= irq_set | (irq_status & ~(wr_status ? wdata_in[IRQ_W-1:0] : RST_IRQ));
            if (wr_mask) begin
                irq_mask <= wdata_in[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] ctl_view = {osc_enable, missing_clk_detect_enable, osc_fail_flag, timer_run,
                           alarm_enable, alarm_flag, timer_load_request,
                           timer_snapshot_request};

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (addr_in)
            OFS_SNAP0, OFS_SNAP1,
            OFS_SNAP2, OFS_SNAP3:   rd_mux = snapshot_holding_regs[lane*8 +: 8];
            OFS_CONTROL:            rd_mux = ctl_view;
            OFS_MATCH0, OFS_MATCH1,
            OFS_MATCH2, OFS_MATCH3: rd_mux = alarm_match_regs[lane*8 +: 8];
            OFS_IRQ_STATUS:         rd_mux = {4'h0, irq_status};
            OFS_IRQ_MASK:           rd_mux = {4'h0, irq_mask};
            default:                rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_out      <= 8'h00;
            osc_enable_out <= 1'b0;
            alarm_out      <= 1'b0;
            irq_out        <= 1'b0;
        end else begin
            rdata_out      <= rd_in ? rd_mux : 8'h00;
            osc_enable_out <= osc_enable;
            alarm_out      <= alarm_flag;
            irq_out        <= |(irq_status & irq_mask);
        end
    end

endmodule : rtcc_top

// file: rtcc_checker.sv
`timescale 1ns/1ps
module rtcc_checker
    import rtcc_pkg::*;
#(
    parameter int unsigned MISS_LIMIT = MISS_CYCLES
) (
    // Clock and reset
    input wire logic              clock_in,
    input wire logic              srst_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    // Oscillator and events
    input wire logic              osc_clk_in,
    input wire logic              osc_enable_out,
    input wire logic              alarm_out,
    input wire logic              irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire logic ctl_wr = wr_in && (addr_in == OFS_CONTROL);
    wire logic gap_rd = rd_in && (addr_in inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
    // Counts rising pin edges while the event flag is high; two means it outlived a period.
    logic [1:0] edges;
    always_ff @(posedge clock_in) begin
        if (srst_in || !alarm_out) begin
            edges <= 2'h0;
        end else if ($rose(osc_clk_in) && edges != 2'h3) begin
            edges <= edges + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_osc_en_follow: assert property (ctl_wr |->
        ##[1:3] osc_enable_out == $past(wdata_in[BIT_OSC_EN], 2))
        else $error("oscillator enable does not follow the control write");
    a_osc_en_cause: assert property ($changed(osc_enable_out) |->
        $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
        else $error("oscillator enable changed without a control write");
    a_alarm_short: assert property (edges < 2'h2)
        else $error("alarm flag stood longer than one oscillator period");
    a_alarm_wr_clear: assert property (alarm_out && ctl_wr |-> ##[1:3] !alarm_out)
        else $error("control write did not clear the alarm flag");
    a_reset_quiet: assert property ($fell(srst_in) |->
        rdata_out == 8'h00 && !osc_enable_out && !alarm_out && !irq_out)
        else $error("outputs not quiet after reset");
    a_irq_masked: assert property (wr_in && addr_in == OFS_IRQ_MASK && wdata_in == 8'h00
        |-> ##[1:3] !irq_out)
        else $error("interrupt stays high with all sources masked");
    a_unmapped_zero: assert property (gap_rd |=> rdata_out == 8'h00)
        else $error("unmapped address read non zero");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data present without a read");

    c_alarm: cover property ($rose(alarm_out));
    c_irq: cover property ($rose(irq_out));
    c_load: cover property (ctl_wr && wdata_in[BIT_LOAD]);
endmodule : rtcc_checker

bind rtcc_top rtcc_checker #(.MISS_LIMIT(MISS_LIMIT)) u_chk (
    .clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .osc_clk_in(osc_clk_in),
    .osc_enable_out(osc_enable_out), .alarm_out(alarm_out), .irq_out(irq_out)
);

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import rtcc_pkg::*;
    logic              clock_in = 1'b0;
    logic              srst_in  = 1'b1;
    logic              wr_in    = 1'b0;
    logic              rd_in    = 1'b0;
    logic              osc_clk_in = 1'b0;
    logic [ADDR_W-1:0] addr_in  = 4'h0;
    logic [DATA_W-1:0] wdata_in = 8'h00;
    logic [DATA_W-1:0] rdata_out;
    logic              osc_enable_out;
    logic              alarm_out;
    logic              irq_out;
    int                n_mismatch = 0;
    int                total_checks = 0;

    // Short detector limit keeps the missing-clock case brief.
    rtcc_top #(.MISS_LIMIT(20)) u_dut (
        .clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .osc_clk_in(osc_clk_in),
        .osc_enable_out(osc_enable_out), .alarm_out(alarm_out), .irq_out(irq_out)
    );

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cyc
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask : rdchk
    task automatic wr32(input logic [3:0] b, input logic [31:0] v);
        for (int i = 0; i < 4; i++) wr(b + 4'(i), v[8*i+:8]);
    endtask : wr32
    task automatic snapchk(input logic [31:0] e);
        for (int i = 0; i < 4; i++) rdchk(4'(i), e[8*i+:8]);
    endtask : snapchk
    // One oscillator period of 16 system clocks.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock_in);
            osc_clk_in <= 1'b1;
            cyc(8);
            osc_clk_in <= 1'b0;
            cyc(7);
        end
    endtask : ticks
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    initial begin
        #200us;
        n_mismatch++;
        summarize();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        cyc(6);
        srst_in <= 1'b0;
        rdchk(OFS_CONTROL, 8'h00);
        snapchk(32'h0);
        rdchk(4'hF, 8'h00);
        wr(OFS_CONTROL, 8'h80);
        cyc(3);
        chk({7'h0, osc_enable_out}, 8'h01);
        wr32(OFS_SNAP0, 32'h10);
        wr(OFS_CONTROL, 8'h92);
        rdchk(OFS_CONTROL, 8'h92);
        ticks(1);
        rdchk(OFS_CONTROL, 8'h90);
        rdchk(OFS_IRQ_STATUS, 8'h04);
        ticks(5);
        wr(OFS_CONTROL, 8'h91);
        ticks(1);
        rdchk(OFS_CONTROL, 8'h90);
        snapchk(32'h15);
        wr(OFS_CONTROL, 8'h80);
        ticks(3);
        wr(OFS_CONTROL, 8'h81);
        ticks(1);
        snapchk(32'h16);
        rdchk(OFS_IRQ_STATUS, 8'h0C);
        wr(OFS_IRQ_STATUS, 8'h0F);
        rdchk(OFS_IRQ_STATUS, 8'h00);
        wr32(OFS_SNAP0, 32'h40);
        wr32(OFS_MATCH0, 32'h40);
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_CONTROL, 8'h9E);
        ticks(2);
        chk({7'h0, alarm_out}, 8'h01);
        rdchk(OFS_CONTROL, 8'h9C);
        chk({7'h0, irq_out}, 8'h01);
        ticks(1);
        chk({7'h0, alarm_out}, 8'h00);
        wr(OFS_CONTROL, 8'h9D);
        ticks(1);
        snapchk(32'h0);
        wr(OFS_IRQ_MASK, 8'h00);
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        wr32(OFS_SNAP0, 32'h40);
        wr(OFS_CONTROL, 8'h8A);
        ticks(2);
        chk({7'h0, alarm_out}, 8'h01);
        wr(OFS_CONTROL, 8'h88);
        cyc(2);
        chk({7'h0, alarm_out}, 8'h00);
        rdchk(OFS_CONTROL, 8'h88);
        ticks(2);
        wr(OFS_CONTROL, 8'h89);
        ticks(1);
        snapchk(32'h40);
        wr(OFS_IRQ_STATUS, 8'h0F);
        wr(OFS_CONTROL, 8'hC0);
        cyc(40);
        rdchk(OFS_CONTROL, 8'hE0);
        rdchk(OFS_IRQ_STATUS, 8'h02);
        wr(OFS_CONTROL, 8'h80);
        rdchk(OFS_CONTROL, 8'h80);
        // Timer still equals the match value, but the alarm is now off.
        ticks(1);
        rdchk(OFS_IRQ_STATUS, 8'h02);
        summarize();
    end
endmodule : tb
